// ==== cdrsnd_pkg.sv ====
// shared constants and types for the clock recovery and detector block
package cdrsnd_pkg;
  // register addresses
  localparam logic [7:0] ADDR_DET_CFG     = 8'h43;
  localparam logic [7:0] ADDR_NOISE_THR   = 8'h44;
  localparam logic [7:0] ADDR_NOISE_CFG   = 8'h45;
  localparam logic [7:0] ADDR_PROP_CFG    = 8'h46;
  localparam logic [7:0] ADDR_INT_CFG     = 8'h47;
  localparam logic [7:0] ADDR_LEADIN_CFG  = 8'h48;
  localparam logic [7:0] ADDR_CHIP_TOL    = 8'h49;
  localparam logic [7:0] ADDR_BIT_TOL     = 8'h4a;
  localparam logic [7:0] ADDR_TIMEOUT     = 8'h4b;
  localparam logic [7:0] ADDR_SLICER      = 8'h4c;
  localparam logic [7:0] ADDR_RATE_UP     = 8'h60;
  localparam logic [7:0] ADDR_RATE_LO     = 8'h61;
  localparam logic [7:0] ADDR_STATUS      = 8'h62;
  localparam logic [7:0] ADDR_POWER       = 8'h63;
  // reset values
  localparam logic [7:0] RST_DET_CFG      = 8'h00;
  localparam logic [7:0] RST_NOISE_THR    = 8'h00;
  localparam logic [7:0] RST_NOISE_CFG    = 8'h07;
  localparam logic [7:0] RST_PROP_CFG     = 8'he6;
  localparam logic [7:0] RST_INT_CFG      = 8'h65;
  localparam logic [7:0] RST_LEADIN_CFG   = 8'h01;
  localparam logic [7:0] RST_CHIP_TOL     = 8'h0c;
  localparam logic [7:0] RST_BIT_TOL      = 8'h1e;
  localparam logic [7:0] RST_TIMEOUT      = 8'h28;
  localparam logic [7:0] RST_SLICER       = 8'h90;
  localparam logic [7:0] RST_RATE_UP      = 8'h10;
  localparam logic [7:0] RST_RATE_LO      = 8'h10;
  // field positions (lsb)
  localparam int F_READOUT_SEL = 2;
  localparam int F_WAKE_CNT    = 1;
  localparam int F_RUN_CNT     = 0;
  localparam int F_RANGE       = 6;
  localparam int F_MODE        = 4;
  localparam int F_LEVEL       = 2;
  localparam int F_NSLEW       = 0;
  localparam int F_RSLEW       = 6;
  localparam int F_OUTER       = 5;
  localparam int F_INNER       = 4;
  localparam int F_PGAIN       = 2;
  localparam int F_PLIM        = 0;
  localparam int F_RSCALE      = 6;
  localparam int F_IOUT_LIM    = 4;
  localparam int F_IGAIN       = 2;
  localparam int F_IACC_LIM    = 0;
  localparam int F_RATE_LIM    = 2;
  localparam int F_LEADIN      = 0;
  localparam int F_LATE        = 3;
  localparam int F_EARLY       = 0;
  // timing in 1/16-bit samples; loop values carry 8 fraction bits per sample
  localparam logic [3:0] HALF_BIT_SAMPLES = 4'h8;
  localparam logic [3:0] CHIP_BORDER      = 4'h8;
  localparam int         FRAC_BITS        = 8;
  localparam logic [5:0] LEADIN_UNIT_BITS = 6'h08;

  typedef logic signed [15:0] cdrsnd_fix_t;

  typedef struct packed {
    logic       valid;
    logic       edge_seen;
    logic [7:0] power;
    logic [7:0] low_sig;
    logic [7:0] noise;
    logic [7:0] amp;
  } cdrsnd_smp_s;

  typedef struct packed {
    logic              valid;
    logic signed [7:0] err;
  } cdrsnd_rate_s;

  typedef enum logic [2:0] {
    LI_IDLE  = 3'b001,
    LI_MEAS  = 3'b010,
    LI_TRACK = 3'b100
  } cdrsnd_li_e;
endpackage

// ==== cdrsnd_core.sv ====
// clock and data recovery loop with signal and noise detectors
`timescale 1ns/1ps
`default_nettype none
module cdrsnd_core
  import cdrsnd_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [7:0]        reg_rdata,
  input  wire cdrsnd_smp_s  smp,
  input  wire cdrsnd_rate_s rate,
  input  wire logic         wake_mode,
  input  wire logic [7:0]   run_threshold,
  input  wire logic [7:0]   wake_threshold,
  input  wire logic [7:0]   low_level_signal_threshold,
  input  wire logic         leadin_sequence,
  output logic [7:0]        signal_power_readout,
  output logic              signal_detect,
  output logic              noise_detect,
  output logic              carrier_detect,
  output logic [7:0]        recovery_peak,
  output logic [3:0]        recovered_phase,
  output logic signed [3:0] phase_step,
  output logic              bit_strobe,
  output logic              edge_accept,
  output logic              sync_loss,
  output logic [7:0]        slicer_setting
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic cdrsnd_fix_t sat(input cdrsnd_fix_t v, input cdrsnd_fix_t lim);
    if (v > lim) begin
      sat = lim;
    end else if (v < -lim) begin
      sat = -lim;
    end else begin
      sat = v;
    end
  endfunction

  function automatic logic [15:0] slew(input logic [15:0] pk, input logic [7:0] x,
                                       input logic [3:0] sh);
    logic signed [16:0] diff;
    diff = $signed({1'b0, x, 8'h00}) - $signed({1'b0, pk});
    slew = 16'($signed({1'b0, pk}) + (diff >>> sh));
  endfunction

  function automatic cdrsnd_fix_t lim_of(input logic [1:0] code, input cdrsnd_fix_t base);
    lim_of = base <<< code;
  endfunction

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] det_cfg_q, noise_thr_q, noise_cfg_q, prop_cfg_q, int_cfg_q;
  logic [7:0] leadin_cfg_q, chip_tol_q, bit_tol_q, timeout_q, slicer_q;
  logic [7:0] rate_up_q, rate_lo_q, reg_rdata_q;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      det_cfg_q    <= RST_DET_CFG;
      noise_thr_q  <= RST_NOISE_THR;
      noise_cfg_q  <= RST_NOISE_CFG;
      prop_cfg_q   <= RST_PROP_CFG;
      int_cfg_q    <= RST_INT_CFG;
      leadin_cfg_q <= RST_LEADIN_CFG;
      chip_tol_q   <= RST_CHIP_TOL;
      bit_tol_q    <= RST_BIT_TOL;
      timeout_q    <= RST_TIMEOUT;
      slicer_q     <= RST_SLICER;
      rate_up_q    <= RST_RATE_UP;
      rate_lo_q    <= RST_RATE_LO;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_DET_CFG:    det_cfg_q    <= {5'h00, reg_wdata[2:0]};
        ADDR_NOISE_THR:  noise_thr_q  <= reg_wdata;
        ADDR_NOISE_CFG:  noise_cfg_q  <= reg_wdata;
        ADDR_PROP_CFG:   prop_cfg_q   <= reg_wdata;
        ADDR_INT_CFG:    int_cfg_q    <= reg_wdata;
        ADDR_LEADIN_CFG: leadin_cfg_q <= {5'h00, reg_wdata[2:0]};
        ADDR_CHIP_TOL:   chip_tol_q   <= {2'h0, reg_wdata[5:0]};
        ADDR_BIT_TOL:    bit_tol_q    <= {2'h0, reg_wdata[5:0]};
        ADDR_TIMEOUT:    timeout_q    <= reg_wdata;
        ADDR_SLICER:     slicer_q     <= reg_wdata;
        ADDR_RATE_UP:    rate_up_q    <= reg_wdata;
        ADDR_RATE_LO:    rate_lo_q    <= reg_wdata;
        default: ;
      endcase
    end
  end

  logic [7:0] rd_val;
  always_comb begin
    case (reg_addr)
      ADDR_DET_CFG:    rd_val = det_cfg_q;
      ADDR_NOISE_THR:  rd_val = noise_thr_q;
      ADDR_NOISE_CFG:  rd_val = noise_cfg_q;
      ADDR_PROP_CFG:   rd_val = prop_cfg_q;
      ADDR_INT_CFG:    rd_val = int_cfg_q;
      ADDR_LEADIN_CFG: rd_val = leadin_cfg_q;
      ADDR_CHIP_TOL:   rd_val = chip_tol_q;
      ADDR_BIT_TOL:    rd_val = bit_tol_q;
      ADDR_TIMEOUT:    rd_val = timeout_q;
      ADDR_SLICER:     rd_val = slicer_q;
      ADDR_RATE_UP:    rd_val = rate_up_q;
      ADDR_RATE_LO:    rd_val = rate_lo_q;
      ADDR_STATUS:     rd_val = {4'h0, sync_loss, carrier_detect, noise_detect, signal_detect};
      ADDR_POWER:      rd_val = signal_power_readout;
      default:         rd_val = 8'h00;
    endcase
  end

  // data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_rd ? rd_val : 8'h00;
    end
  end
  assign reg_rdata      = reg_rdata_q;
  assign slicer_setting = slicer_q;

  // ****************************************
  // signal detector
  // ****************************************
  logic [7:0] cur_thr;
  logic       cnt_en, above, low_ok;
  logic [3:0] qual_q;
  logic       sig_d;
  assign cur_thr = wake_mode ? wake_threshold : run_threshold;
  assign cnt_en  = wake_mode ? det_cfg_q[F_WAKE_CNT] : det_cfg_q[F_RUN_CNT];
  assign above   = smp.power > cur_thr;
  assign low_ok  = smp.low_sig > low_level_signal_threshold;
  // with the mode's count enabled, qualified only after a half bit of consecutive samples above threshold; otherwise at once
  assign sig_d   = above && (!cnt_en || qual_q == HALF_BIT_SAMPLES - 4'h1);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      qual_q <= 4'h0;
    end else if (smp.valid) begin
      if (!above) begin
        qual_q <= 4'h0;
      end else if (qual_q != HALF_BIT_SAMPLES - 4'h1) begin
        qual_q <= qual_q + 4'h1;
      end
    end
  end

  // ****************************************
  // noise detector and mode selection
  // ****************************************
  logic [15:0] npk_q, rpk_q, nlvl, nthr;
  logic        noise_ok, noise_d, carrier_d;
  always_comb begin
    case (noise_cfg_q[F_LEVEL +: 2])
      2'h0:    nlvl = npk_q >> 1;
      2'h1:    nlvl = (npk_q >> 2) + (npk_q >> 3);
      2'h2:    nlvl = npk_q >> 2;
      default: nlvl = npk_q >> 3;
    endcase
  end
  assign nthr     = 16'(noise_thr_q) << (3'h7 - {1'b0, noise_cfg_q[F_RANGE +: 2]});
  assign noise_ok = nlvl < nthr;
  assign noise_d  = (noise_cfg_q[F_MODE +: 2] == 2'h3) ? (noise_ok && low_ok) : noise_ok;

  always_comb begin
    case (noise_cfg_q[F_MODE +: 2])
      2'h0:    carrier_d = sig_d;
      2'h1:    carrier_d = noise_ok;
      2'h2:    carrier_d = sig_d && noise_ok;
      default: carrier_d = sig_d && noise_ok && low_ok;
    endcase
  end

  logic [3:0] rup_sh, rdn_sh;
  always_comb begin
    case (prop_cfg_q[F_RSLEW +: 2])
      2'h0:    begin rup_sh = 4'h6; rdn_sh = 4'h6; end
      2'h1:    begin rup_sh = 4'h6; rdn_sh = 4'h7; end
      2'h2:    begin rup_sh = 4'h5; rdn_sh = 4'h7; end
      default: begin rup_sh = 4'h5; rdn_sh = 4'h8; end
    endcase
  end

  logic [7:0] readout_q;
  logic       sig_q, noise_q, carrier_q;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      npk_q     <= 16'h0000;
      rpk_q     <= 16'h0000;
      readout_q <= 8'h00;
      sig_q     <= 1'b0;
      noise_q   <= 1'b0;
      carrier_q <= 1'b0;
    end else if (smp.valid) begin
      npk_q     <= slew(npk_q, smp.noise, 4'h8 - {2'h0, noise_cfg_q[F_NSLEW +: 2]});
      rpk_q     <= slew(rpk_q, smp.amp, ({smp.amp, 8'h00} > rpk_q) ? rup_sh : rdn_sh);
      readout_q <= det_cfg_q[F_READOUT_SEL] ? smp.low_sig : smp.power;
      sig_q     <= sig_d;
      noise_q   <= noise_d;
      carrier_q <= carrier_d;
    end
  end
  assign signal_power_readout = readout_q;
  assign signal_detect        = sig_q;
  assign noise_detect         = noise_q;
  assign carrier_detect       = carrier_q;
  assign recovery_peak        = rpk_q[15:8];

  // ****************************************
  // edge classification and phase error
  // ****************************************
  logic [3:0]        phase_q;
  logic              at_chip;
  logic signed [4:0] tol_err, phase_error, pde_z;
  logic [2:0]        late_tol, early_tol;
  logic              edge_ok_d;
  // mid-bit edges land near the chip border, the rest near the bit border
  assign at_chip   = phase_q >= 4'h4 && phase_q <= 4'hb;
  assign tol_err   = at_chip ? 5'($signed({1'b0, phase_q}) - $signed({1'b0, CHIP_BORDER}))
                             : 5'($signed(phase_q));
  assign late_tol  = at_chip ? chip_tol_q[F_LATE +: 3] : bit_tol_q[F_LATE +: 3];
  assign early_tol = at_chip ? chip_tol_q[F_EARLY +: 3] : bit_tol_q[F_EARLY +: 3];
  assign edge_ok_d = smp.edge_seen && ((tol_err >= 0) ? (tol_err <= $signed({2'b0, late_tol}))
                   : (-tol_err <= $signed({2'b0, early_tol})));
  assign phase_error       = 5'($signed(phase_q));
  // bit-border error; chip edges at -8 fall outside the outer band and drop out
  always_comb begin
    pde_z = phase_error;
    if (prop_cfg_q[F_OUTER] && (phase_error > 5'sd7 || phase_error < -5'sd7)) begin
      pde_z = 5'sd0;
    end
    if (prop_cfg_q[F_INNER] && phase_error == 5'sd0) begin
      pde_z = 5'sd0;
    end
  end

  // ****************************************
  // loop filter, lead-in and phase accumulator
  // ****************************************
  cdrsnd_fix_t err_fix, p_d, i_inc, iacc_d, iout, tot, preload;
  cdrsnd_fix_t p_q, iacc_q, frac_q;
  logic signed [3:0] step;
  logic              rate_ok, li_done;
  logic [5:0]        li_cnt_q;
  logic signed [7:0] rate_q;
  cdrsnd_li_e        li_q;
  logic [3:0]        pre_sh;

  assign err_fix = cdrsnd_fix_t'(pde_z) <<< FRAC_BITS;
  assign p_d     = sat(err_fix >>> prop_cfg_q[F_PGAIN +: 2],
                       lim_of(prop_cfg_q[F_PLIM +: 2], 16'sd256));
  assign i_inc   = err_fix >>> (4'h5 + {2'b0, int_cfg_q[F_IGAIN +: 2]});
  assign iacc_d  = sat(iacc_q + i_inc, lim_of(int_cfg_q[F_IACC_LIM +: 2], 16'sd256));
  assign iout    = sat(iacc_q, lim_of(int_cfg_q[F_IOUT_LIM +: 2], 16'sd128));
  assign tot     = 16'(frac_q + p_q + iout);
  assign step    = ($signed(tot[15:8]) > 8'sd7) ? 4'sd7
                 : ($signed(tot[15:8]) < -8'sd8) ? -4'sd8 : 4'(tot[11:8]);
  assign pre_sh  = (int_cfg_q[F_RSCALE +: 2] == 2'h3) ? 4'h5
                 : (int_cfg_q[F_RSCALE +: 2] == 2'h2) ? 4'h4 : 4'h2;
  assign preload = sat((cdrsnd_fix_t'(rate_q) <<< FRAC_BITS) >>> pre_sh,
                       lim_of(int_cfg_q[F_IACC_LIM +: 2], 16'sd256));
  assign rate_ok = !leadin_cfg_q[F_RATE_LIM] ||
                   (rate_q <= $signed({1'b0, rate_up_q[6:0]}) &&
                    rate_q >= -$signed({1'b0, rate_lo_q[6:0]}));
  // longer lead-in buys a better rate estimate at the cost of sync time
  assign li_done = li_q == LI_MEAS && smp.valid && phase_q == 4'hf &&
                   li_cnt_q == 6'((leadin_cfg_q[1:0] + 6'h1) * LEADIN_UNIT_BITS - 6'h1);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rate_q <= 8'sh00;
    end else if (rate.valid) begin
      rate_q <= rate.err;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      li_q     <= LI_IDLE;
      li_cnt_q <= 6'h00;
    end else begin
      case (li_q)
        LI_IDLE: begin
          li_cnt_q <= 6'h00;
          if (leadin_sequence) begin
            li_q <= LI_MEAS;
          end
        end
        LI_MEAS: begin
          if (li_done) begin
            li_q <= LI_TRACK;
          end else if (smp.valid && phase_q == 4'hf) begin
            li_cnt_q <= li_cnt_q + 6'h1;
          end
        end
        LI_TRACK: begin
          if (sync_loss) begin
            li_q <= LI_IDLE;
          end
        end
        default: li_q <= LI_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      iacc_q <= 16'sh0000;
    end else if (li_done && rate_ok) begin
      iacc_q <= preload;
    end else if (smp.valid && edge_ok_d) begin
      iacc_q <= iacc_d;
    end
  end

  logic              strobe_q;
  logic signed [3:0] step_q;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      phase_q  <= 4'h0;
      p_q      <= 16'sh0000;
      frac_q   <= 16'sh0000;
      step_q   <= 4'sh0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= smp.valid && phase_q == 4'hf;
      if (smp.valid && phase_q == 4'hf) begin
        // one correction per symbol; fraction carried to the next
        phase_q <= 4'(-step);
        step_q  <= step;
        frac_q  <= 16'(tot - (cdrsnd_fix_t'(step) <<< FRAC_BITS));
        p_q     <= 16'sh0000;
      end else if (smp.valid) begin
        phase_q <= phase_q + 4'h1;
        if (edge_ok_d) begin
          p_q <= p_d;
        end
      end
    end
  end
  assign recovered_phase = phase_q;
  assign phase_step      = step_q;
  assign bit_strobe      = strobe_q;

  // ****************************************
  // edge timeout
  // ****************************************
  logic [7:0] to_cnt_q, to_nxt;
  logic       loss_q, acc_q;
  assign to_nxt = (to_cnt_q == 8'hff) ? 8'hff : to_cnt_q + 8'h1;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      to_cnt_q <= 8'h00;
      loss_q   <= 1'b0;
      acc_q    <= 1'b0;
    end else begin
      acc_q <= smp.valid && edge_ok_d;
      if (smp.valid && edge_ok_d) begin
        to_cnt_q <= 8'h00;
        loss_q   <= 1'b0;
      end else if (smp.valid) begin
        to_cnt_q <= to_nxt;
        if (to_nxt >= timeout_q) begin
          loss_q <= 1'b1;
        end
      end
    end
  end
  assign sync_loss   = loss_q;
  assign edge_accept = acc_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_below;
    smp.valid && !above;
  endsequence
  sequence s_edge;
    smp.valid && edge_ok_d;
  endsequence

  property p_readout;
    smp.valid |=> signal_power_readout ==
      ($past(det_cfg_q[F_READOUT_SEL]) ? $past(smp.low_sig) : $past(smp.power));
  endproperty
  a_readout: assert property (p_readout) else $error("readout source wrong");

  property p_below;
    s_below |=> !signal_detect && (qual_q == 4'h0);
  endproperty
  a_below: assert property (p_below) else $error("detect while below threshold");

  property p_qual;
    smp.valid && above && cnt_en && qual_q < 4'h7 |=> !signal_detect;
  endproperty
  a_qual: assert property (p_qual) else $error("detect before half bit");

  property p_mode0;
    smp.valid && noise_cfg_q[F_MODE +: 2] == 2'h0 |=> carrier_detect == signal_detect;
  endproperty
  a_mode0: assert property (p_mode0) else $error("mode 0 not signal only");

  property p_outer;
    s_edge and (phase_q == 4'h8) and prop_cfg_q[F_OUTER] |=> p_q == 16'sh0000;
  endproperty
  a_outer: assert property (p_outer) else $error("outer deadband ignored");

  property p_plim;
    s_edge and (phase_q != 4'hf) |=>
      p_q <= lim_of($past(prop_cfg_q[F_PLIM +: 2]), 16'sd256) &&
      p_q >= -lim_of($past(prop_cfg_q[F_PLIM +: 2]), 16'sd256);
  endproperty
  a_plim: assert property (p_plim) else $error("proportional over limit");

  property p_late;
    smp.valid && smp.edge_seen && tol_err > $signed({2'b0, late_tol}) |=> !edge_accept;
  endproperty
  a_late: assert property (p_late) else $error("late edge accepted");

  property p_loss;
    $rose(sync_loss) |-> to_cnt_q >= timeout_q && !edge_accept;
  endproperty
  a_loss: assert property (p_loss) else $error("sync loss before window");

  property p_clear;
    s_edge |=> !sync_loss && to_cnt_q == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("edge did not clear timeout");

  property p_preload;
    li_done && rate_ok |=> iacc_q == $past(preload) ##1 li_q == LI_TRACK || sync_loss;
  endproperty
  a_preload: assert property (p_preload) else $error("lead-in preload missing");

endmodule
`default_nettype wire

// ==== cdrsnd_src.sv ====
// sample stream source standing in for the receive chain
`timescale 1ns/1ps
`default_nettype none
module cdrsnd_src
  import cdrsnd_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       run,
  input  wire logic [7:0] power,
  input  wire logic [7:0] low_sig,
  input  wire logic       edge_req,
  output cdrsnd_smp_s     smp
);
  logic [7:0] noise_q = 8'h00;
  // idle samples carry inverted power and low_sig and a noise field that keeps counting, so a stale value never passes for a fresh one
  always_ff @(posedge mclk) begin
    noise_q <= noise_q + 8'h05;
  end
  always_comb begin
    smp.valid     = run;
    smp.edge_seen = run & edge_req;
    smp.power     = run ? power : ~power;
    smp.low_sig   = run ? low_sig : ~low_sig;
    smp.noise     = noise_q;
    smp.amp       = noise_q ^ 8'h5a;
  end
endmodule
`default_nettype wire

// ==== cdrsnd_core_bench.sv ====
// self-checking bench for the clock recovery and detector block
`timescale 1ns/1ps
`default_nettype none
module cdrsnd_core_bench
  import cdrsnd_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst_b = 1'b0;
  logic [7:0]   reg_addr = 8'h00;
  logic [7:0]   reg_wdata = 8'h00;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [7:0]   reg_rdata;
  cdrsnd_smp_s  smp;
  logic         wake_mode = 1'b0;
  logic [7:0]   thr = 8'h40;
  logic         run = 1'b0;
  logic [7:0]   power = 8'h80;
  logic         edge_req = 1'b0;
  logic [7:0]   spr;
  logic         sig_det;
  logic         sync_loss;
  logic         noise_det;
  logic         carrier_det;
  logic         edge_acc;
  logic         leadin = 1'b0;
  cdrsnd_rate_s rate_in = 9'h140;
  logic [3:0]   rphase;
  logic [3:0]   pstep;
  logic [7:0]   sls;
  logic [7:0]   rd_q;
  int           mismatches = 0;
  int           num_checks = 0;
  int           cycles = 0;
  // ************************************************************
  // clock, reset and instances
  // ************************************************************
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  cdrsnd_src i_cdrsnd_src (.mclk(mclk), .run(run), .power(power), .low_sig(8'h33),
    .edge_req(edge_req), .smp(smp));
  cdrsnd_core i_cdrsnd_core (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .smp(smp), .rate(rate_in), .wake_mode(wake_mode), .run_threshold(thr),
    .wake_threshold(thr), .low_level_signal_threshold(8'h00), .leadin_sequence(leadin),
    .signal_power_readout(spr), .signal_detect(sig_det), .noise_detect(noise_det),
    .carrier_detect(carrier_det), .recovery_peak(), .recovered_phase(rphase),
    .phase_step(pstep), .bit_strobe(), .edge_accept(edge_acc), .sync_loss(sync_loss),
    .slicer_setting(sls));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  // n valid samples, then one idle edge so the last answer has landed
  task automatic stream(input int n);
    repeat (n) begin
      @(posedge mclk);
      run <= 1'b1;
    end
    @(posedge mclk);
    run <= 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    logic [7:0] a [0:8] = '{ADDR_DET_CFG, ADDR_NOISE_THR, ADDR_NOISE_CFG, ADDR_PROP_CFG,
      ADDR_INT_CFG, ADDR_LEADIN_CFG, ADDR_CHIP_TOL, ADDR_BIT_TOL, ADDR_TIMEOUT};
    logic [7:0] v [0:8] = '{8'h00, 8'h00, 8'h07, 8'he6, 8'h65, 8'h01, 8'h0c, 8'h1e, 8'h28};
    for (int i = 0; i < 9; i++) begin
      rd(a[i]);
      chk("reset value", v[i], rd_q);
    end
    rd(8'h50);
    chk("unmapped read", 8'h00, rd_q);
    rd(ADDR_SLICER);
    chk("slicer reset", 8'h90, rd_q);
    chk("slicer port", 8'h90, sls);
    wr(ADDR_DET_CFG, 8'hff);
    rd(ADDR_DET_CFG);
    chk("config width", 8'h07, rd_q);
    wr(ADDR_DET_CFG, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_detect();
    for (int m = 0; m < 2; m++) begin
      wake_mode <= m[0];
      power <= 8'h80;
      stream(1);
      chk("detect plain", 8'h01, {7'h0, sig_det});
      chk("phase count", m[0] ? 8'h0b : 8'h01, {4'h0, rphase});
      power <= 8'h10;
      stream(1);
      chk("detect below", 8'h00, {7'h0, sig_det});
      wr(ADDR_DET_CFG, 8'h01 << m);
      power <= 8'h80;
      stream(4);
      chk("detect half", 8'h00, {7'h0, sig_det});
      stream(4);
      chk("detect qualified", 8'h01, {7'h0, sig_det});
      wr(ADDR_DET_CFG, 8'h00);
    end
    $display("test detect done");
  endtask
  task automatic t_readout();
    power <= 8'h80;
    stream(1);
    chk("readout power", 8'h80, spr);
    wr(ADDR_DET_CFG, 8'h04);
    stream(1);
    chk("readout low", 8'h33, spr);
    wr(ADDR_DET_CFG, 8'h00);
    $display("test readout done");
  endtask
  task automatic t_noise();
    power <= 8'h10;
    wr(ADDR_NOISE_THR, 8'hff);
    stream(1);
    chk("noise quiet", 8'h01, {7'h0, noise_det});
    chk("carrier signal only", 8'h00, {7'h0, carrier_det});
    wr(ADDR_NOISE_CFG, 8'h17);
    stream(1);
    chk("carrier noise only", 8'h01, {7'h0, carrier_det});
    wr(ADDR_NOISE_THR, 8'h00);
    stream(1);
    chk("noise over zero", 8'h00, {7'h0, noise_det});
    chk("carrier noise off", 8'h00, {7'h0, carrier_det});
    wr(ADDR_NOISE_CFG, 8'h07);
    $display("test noise done");
  endtask
  // no edges here, so only the integral path moves the sampling phase
  task automatic t_leadin();
    wr(ADDR_LEADIN_CFG, 8'h04);
    leadin <= 1'b1;
    stream(176);
    chk("rate refused", 8'h00, {4'h0, pstep});
    wr(ADDR_LEADIN_CFG, 8'h00);
    stream(176);
    leadin <= 1'b0;
    chk("rate preload", 8'h02, {4'h0, pstep});
    $display("test leadin done");
  endtask
  task automatic t_window();
    wr(ADDR_TIMEOUT, 8'h0a);
    wr(ADDR_CHIP_TOL, 8'h3f);
    edge_req <= 1'b1;
    @(posedge mclk);
    run <= 1'b1;
    @(posedge mclk);
    run <= 1'b0;
    edge_req <= 1'b0;
    #1;
    chk("edge accept", 8'h01, {7'h0, edge_acc});
    chk("loss cleared", 8'h00, {7'h0, sync_loss});
    stream(9);
    chk("edge pulse ends", 8'h00, {7'h0, edge_acc});
    chk("early loss", 8'h00, {7'h0, sync_loss});
    stream(1);
    chk("loss after window", 8'h01, {7'h0, sync_loss});
    $display("test window done");
  endtask
  // ************************************************************
  // main sequence and timeout
  // ************************************************************
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_detect();
    t_readout();
    t_noise();
    t_leadin();
    t_window();
    close_out();
  end
endmodule
`default_nettype wire
